// *** bench/iaf_flash_model.sv ***
/*
  behavioural flash array: erased bytes read ff, program only clears bits.
  assumes level strobes from the sequencer and a stable address meanwhile.
*/
`default_nettype none
module iaf_flash_model
#(
  parameter int PAGE_BYTES = 128
)
(
  input wire logic core_clk,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_read,
  input wire logic [1:0] flash_area,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  output var logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [17:0]];
  logic prog_d_r = 1'b0;
  logic erase_d_r = 1'b0;
  wire logic [17:0] key = {flash_area, flash_addr};
  initial flash_rdata = 8'hA5;
  always @(posedge core_clk)
  begin
    // idle bus toggles so a stale sample never looks right
    flash_rdata <= flash_read ? (mem.exists(key) ? mem[key] : 8'hFF) : ~flash_rdata;
    if (prog_d_r && !flash_prog)
      mem[key] = (mem.exists(key) ? mem[key] : 8'hFF) & flash_wdata;
    if (erase_d_r && !flash_erase)
      for (int i = 0; i < PAGE_BYTES; i++)
        mem.delete((key & ~18'(PAGE_BYTES - 1)) + 18'(i));
    prog_d_r <= flash_prog;
    erase_d_r <= flash_erase;
  end
endmodule
`default_nettype wire

// *** bench/iaf_top_assertions.sv ***
/*
  port-level assertions for the flash sequencer.
  assumes one clock, synchronous active-low reset, bound to iaf_top.
*/
`default_nettype none
module iaf_top_assertions
  import iaf_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_hold,
  input wire logic osc_en,
  input wire logic pump_en,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_read,
  input wire logic supply_below_bod
);
  logic [17:0] run_cnt_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // pump cycle counter
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst || !pump_en)
      run_cnt_r <= 18'h00000;
    else
      run_cnt_r <= run_cnt_r + 18'h00001;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_go_starts_hold:
    assert property ($rose(cpu_hold) |-> $past(reg_wr) && $past(reg_addr) == ADR_TRIGGER
      && $past(reg_wdata[0]) && $past(osc_en))
    else $error("hold rose without trigger write");
  a_off_no_start:
    assert property (reg_wr && reg_addr == ADR_TRIGGER && !osc_en |=> !cpu_hold)
    else $error("operation started while disabled");
  a_osc_in_hold:
    assert property (cpu_hold |-> osc_en)
    else $error("oscillator off during operation");
  a_strobe_in_hold:
    assert property ((flash_erase || flash_prog || flash_read) |-> cpu_hold)
    else $error("flash strobe without cpu hold");
  a_pump_on_write:
    assert property (pump_en == (flash_erase || flash_prog))
    else $error("pump not tied to erase or program");
  a_read_two:
    assert property ($rose(flash_read) |-> flash_read[*2] ##1 !flash_read)
    else $error("read strobe length wrong");
  a_end_release:
    assert property ($fell(flash_erase || flash_prog || flash_read) |-> cpu_hold ##1 !cpu_hold)
    else $error("cpu not released one cycle after run");
  a_prog_time:
    assert property ($fell(pump_en) && $past(flash_prog) && !$past(supply_below_bod)
      |-> run_cnt_r == 18'(PROG_CYC))
    else $error("program time wrong");
  a_erase_time:
    assert property ($fell(pump_en) && $past(flash_erase) && !$past(supply_below_bod)
      |-> run_cnt_r == 18'(ERASE_CYCLES))
    else $error("erase time wrong");
  a_rdata_after_rd:
    assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside its slot");
endmodule
bind iaf_top iaf_top_assertions #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_hold(cpu_hold),
  .osc_en(osc_en), .pump_en(pump_en), .flash_erase(flash_erase), .flash_prog(flash_prog),
  .flash_read(flash_read), .supply_below_bod(supply_below_bod));
`default_nettype wire

// *** bench/iaf_top_tb.sv ***
/*
  self-checking bench: table of flash operations, then hand-written cases.
  assumes iaf_top and iaf_flash_model; erase count shortened to 20 cycles.
*/
`default_nettype none
module iaf_top_tb
  import iaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ERASE_T = 20;
  localparam int T_PROG = PROG_CYC + 1;
  localparam int T_ERASE = ERASE_T + 1;
  localparam int T_READ = READ_CYC + 1;
  typedef struct {
    logic [7:0] cmd; logic [15:0] addr; logic [7:0] wd; logic [2:0] upd;
    int hold; logic [2:0] str; logic flt; logic [7:0] rd;
  } iaf_row_t;
  logic core_clk, reg_wr = 1'b0, reg_rd = 1'b0, nrst = 1'b0;
  logic bo_det = 1'b1, bo_rst = 1'b0, bo_low = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, flash_wdata, flash_rdata, v;
  logic irq, cpu_hold, osc_en, pump_en, flash_erase, flash_prog, flash_read;
  logic [1:0] flash_area;
  logic [15:0] flash_addr;
  logic [3:0] s;
  int n, n_mismatch = 0, compares = 0, cyc = 0;
  iaf_row_t r;
  iaf_row_t rows [16];
  logic [7:0] ra [5] = '{ADR_UPD_EN, ADR_CMD, ADR_BO_CFG, ADR_CHIP_CTRL, ADR_DATA};
  logic [7:0] rv [5] = '{8'h00, RST_CMD, RST_BO_CFG, RST_CHIP, RST_BYTE};
  iaf_top #(.ERASE_CYCLES(ERASE_T)) dut (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .cpu_hold(cpu_hold), .osc_en(osc_en),
    .pump_en(pump_en), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_read(flash_read), .flash_area(flash_area), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata), .brownout_detect_on(bo_det),
    .brownout_reset_on(bo_rst), .supply_below_bod(bo_low));
  iaf_flash_model u_flash (.core_clk(core_clk), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_read(flash_read), .flash_area(flash_area),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
  // ----------------------------------------
  // clock, timeout, report
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  // interrupts assumed masked by the caller around this
  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(ADR_TA_LOCK, TA_KEY1);
    wr(ADR_TA_LOCK, TA_KEY2);
    wr(a, d);
  endtask
  // counts hold cycles; strobes sampled in the first hold cycle
  task automatic go(input logic lk);
    if (lk)
    begin
      wr(ADR_TA_LOCK, TA_KEY1);
      wr(ADR_TA_LOCK, TA_KEY2);
    end
    reg_addr <= ADR_TRIGGER;
    reg_wdata <= 8'h01;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1 s = {pump_en, flash_erase, flash_prog, flash_read};
    n = 0;
    while (cpu_hold === 1'b1 && n < 3000)
    begin
      n++;
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic op(input iaf_row_t x);
    wr(ADR_ADDR_HI, x.addr[15:8]);
    wr(ADR_ADDR_LO, x.addr[7:0]);
    wr(ADR_DATA, x.wd);
    wr(ADR_CMD, x.cmd);
    pwr(ADR_UPD_EN, {5'h00, x.upd});
    go(1'b1);
    chk(n == x.hold, "hold length");
    chk(s === {x.str[2] | x.str[1], x.str}, "flash strobes");
    rd(ADR_CHIP_CTRL, v);
    chk(v[CHIP_FAULT_BIT] === x.flt, "fault flag");
    rd(ADR_DATA, v);
    chk(v === x.rd, "data byte");
    rd(ADR_IRQ_STAT, v);
    chk(v[IRQ_FAULT_BIT] === x.flt, "irq fault bit");
  endtask
  task automatic clr;
    pwr(ADR_CHIP_CTRL, 8'h01);
    wr(ADR_IRQ_STAT, 8'h03);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    rows = '{
      '{8'h21, 16'h0010, 8'h5A, 3'h1, T_PROG, 3'h2, 1'b0, 8'h5A},
      '{8'h00, 16'h0010, 8'h00, 3'h1, T_READ, 3'h1, 1'b0, 8'h5A},
      '{8'h22, 16'h0010, 8'h11, 3'h1, T_ERASE, 3'h4, 1'b0, 8'h11},
      '{8'h00, 16'h0010, 8'h00, 3'h0, T_READ, 3'h1, 1'b0, 8'hFF},
      '{8'h61, 16'h0005, 8'h3C, 3'h5, 1, 3'h0, 1'b1, 8'h3C},
      '{8'h40, 16'h0005, 8'h00, 3'h0, T_READ, 3'h1, 1'b0, 8'hFF},
      '{8'h61, 16'h0005, 8'h3C, 3'h2, T_PROG, 3'h2, 1'b0, 8'h3C},
      '{8'h40, 16'h0005, 8'h00, 3'h0, T_READ, 3'h1, 1'b0, 8'h3C},
      '{8'h00, 16'h4000, 8'h77, 3'h0, 1, 3'h0, 1'b1, 8'h77},
      '{8'h0B, 16'h0000, 8'h66, 3'h7, 1, 3'h0, 1'b1, 8'h66},
      '{8'hA1, 16'h0003, 8'h0F, 3'h3, 1, 3'h0, 1'b1, 8'h0F},
      '{8'hA1, 16'h0003, 8'h0F, 3'h4, T_PROG, 3'h2, 1'b0, 8'h0F},
      '{8'h62, 16'h0005, 8'h00, 3'h2, T_ERASE, 3'h4, 1'b0, 8'h00},
      '{8'h40, 16'h1000, 8'h12, 3'h0, 1, 3'h0, 1'b1, 8'h12},
      '{8'h22, 16'h0010, 8'h00, 3'h6, 1, 3'h0, 1'b1, 8'h00},
      '{8'h00, 16'h3FFF, 8'h00, 3'h0, T_READ, 3'h1, 1'b0, 8'hFF}};
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    pwr(ADR_CHIP_CTRL, 8'h01);
    #1 chk(osc_en === 1'b1, "oscillator off after enable");
    foreach (rows[i])
    begin
      op(rows[i]);
      clr;
    end
    // fault stays until software clears it
    op(rows[9]);
    r = rows[15];
    r.flt = 1'b1;
    op(r);
    wr(ADR_IRQ_MASK, 8'h02);
    #1 chk(irq === 1'b1, "irq not raised");
    wr(ADR_IRQ_MASK, 8'h00);
    #1 chk(irq === 1'b0, "irq not masked");
    wr(ADR_IRQ_MASK, 8'h02);
    clr;
    #1 chk(irq === 1'b0, "irq not cleared");
    go(1'b0);
    chk(n == 0, "go taken without unlock");
    wr(ADR_UPD_EN, 8'h07);
    rd(ADR_UPD_EN, v);
    chk(v === 8'h00, "update enables written without unlock");
    r = '{8'h22, 16'h0100, 8'h00, 3'h1, 1, 3'h0, 1'b1, 8'h00};
    bo_low <= 1'b1;
    op(r);
    clr;
    r.hold = T_ERASE;
    r.str = 3'h4;
    r.flt = 1'b0;
    bo_det <= 1'b0;
    op(r);
    bo_det <= 1'b1;
    bo_rst <= 1'b1;
    op(r);
    bo_rst <= 1'b0;
    // supply sags three cycles into an erase: abort, fault, cpu released
    bo_low <= 1'b0;
    r.hold = 5;
    r.flt = 1'b1;
    fork
      op(r);
      begin
        wait (pump_en === 1'b1);
        repeat (3) @(posedge core_clk);
        bo_low <= 1'b1;
      end
    join
    clr;
    r.hold = T_ERASE;
    r.flt = 1'b0;
    wr(ADR_BO_CFG, 8'hF7);
    op(r);
    bo_low <= 1'b0;
    // enable dropped last so the oscillator can stop
    pwr(ADR_CHIP_CTRL, 8'h00);
    #1 chk(osc_en === 1'b0, "oscillator still on");
    go(1'b1);
    chk(n == 0, "go taken while disabled");
    rd(8'h00, v);
    chk(v === 8'h00, "unmapped read not zero");
    rd(ADR_TRIGGER, v);
    chk(v === 8'h00, "go bit reads back set");
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (ra[i])
    begin
      rd(ra[i], v);
      chk(v === rv[i], "reset value");
    end
    test_done;
  end
endmodule
`default_nettype wire

// *** hw/iaf_op_timer.sv ***
/*
  down-counter that times one flash operation from the core clock.
  assumes load is nonzero and start is a single-cycle pulse.
*/
`default_nettype none
module iaf_op_timer
  import iaf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [TMR_W-1:0] load,
  input wire logic abort,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic run;
    logic [TMR_W-1:0] cnt;
  } iaf_tmr_t;

  iaf_tmr_t s;
  iaf_tmr_t n;

  // ----------------------------------------
  // count
  // ----------------------------------------
  always_comb
  begin
    n = s;
    if (start)
    begin
      n.run = 1'b1;
      n.cnt = load;
    end
    else if (abort)
    begin
      n.run = 1'b0;
    end
    else if (s.run)
    begin
      n.cnt = s.cnt - 1'b1;
      if (s.cnt == {{(TMR_W-1){1'b0}}, 1'b1})
      begin
        n.run = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign busy = s.run;
  // abort is left out here so done never loops back through the caller's abort logic
  assign done = s.run && (s.cnt == {{(TMR_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** hw/iaf_pkg.sv ***
/*
  constants, field layout, reset values and types of the flash sequencer.
  assumes an 8-bit register port and a 50 MHz core clock.
*/
`default_nettype none
package iaf_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_CHIP_CTRL = 8'h9F;
  localparam logic [7:0] ADR_TRIGGER = 8'hA4;
  localparam logic [7:0] ADR_UPD_EN = 8'hA5;
  localparam logic [7:0] ADR_ADDR_LO = 8'hA6;
  localparam logic [7:0] ADR_ADDR_HI = 8'hA7;
  localparam logic [7:0] ADR_DATA = 8'hAE;
  localparam logic [7:0] ADR_CMD = 8'hAF;
  localparam logic [7:0] ADR_TA_LOCK = 8'hB8;
  localparam logic [7:0] ADR_BO_CFG = 8'hB9;
  localparam logic [7:0] ADR_IRQ_STAT = 8'hBA;
  localparam logic [7:0] ADR_IRQ_MASK = 8'hBB;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CHIP_EN_BIT = 0;
  localparam int CHIP_BS_BIT = 1;
  localparam int CHIP_FAULT_BIT = 6;
  localparam int UPD_APP_BIT = 0;
  localparam int UPD_LDR_BIT = 1;
  localparam int UPD_CFG_BIT = 2;
  localparam int TRIG_GO_BIT = 0;
  localparam int BO_INHIBIT_BIT = 3;
  localparam int CMD_FC_LSB = 0;
  localparam int CMD_FCEN_BIT = 4;
  localparam int CMD_FOEN_BIT = 5;
  localparam int CMD_BLK_LSB = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CHIP = 8'h00;
  localparam logic [2:0] RST_UPD = 3'h0;
  localparam logic [7:0] RST_CMD = 8'h30;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_BO_CFG = 8'hFF;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [3:0] FC_READ = 4'h0;
  localparam logic [3:0] FC_PROG = 4'h1;
  localparam logic [3:0] FC_ERASE = 4'h2;
  localparam logic [1:0] BLK_APP = 2'h0;
  localparam logic [1:0] BLK_LDR = 2'h1;
  localparam logic [1:0] BLK_CFG = 2'h2;
  localparam logic [7:0] TA_KEY1 = 8'hAA;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ERASE_TIME_MS = 5;
  localparam int PROG_TIME_NS = 23500;
  localparam int ERASE_CYC = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = 2;
  localparam logic [2:0] TA_OPEN_CYC = 3'h4;
  localparam int TMR_W = 18;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_END = 2'b10
  } iaf_state_t;
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10
  } iaf_op_t;
endpackage
`default_nettype wire

// *** hw/iaf_timed_access.sv ***
/*
  timed-access lock: two key writes open a short window for one protected write.
  assumes key writes arrive as single-cycle strobes from the register port.
*/
`default_nettype none
module iaf_timed_access
  import iaf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic lock_wr,
  input wire logic [7:0] lock_wdata,
  input wire logic prot_wr,
  output logic open
);
  typedef struct packed {
    logic key1_seen;
    logic [2:0] open_cnt;
  } iaf_ta_t;

  iaf_ta_t s;
  iaf_ta_t n;

  // ----------------------------------------
  // key sequence
  // ----------------------------------------
  always_comb
  begin
    n = s;
    if (s.open_cnt != 3'h0)
    begin
      n.open_cnt = s.open_cnt - 3'h1;
    end
    if (lock_wr)
    begin
      n.key1_seen = (lock_wdata == TA_KEY1);
      if (s.key1_seen && lock_wdata == TA_KEY2)
      begin
        n.open_cnt = TA_OPEN_CYC;
      end
    end
    // one protected write uses up the window
    if (prot_wr)
    begin
      n.open_cnt = 3'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign open = (s.open_cnt != 3'h0);
endmodule
`default_nettype wire

// *** hw/iaf_top.sv ***
/*
  in-application flash sequencer: registers, checks, timing and flash drive.
  assumes an 8-bit register port with read data one cycle late, a flash
  array that acts on level strobes, and brown-out status from outside.
*/
// Chosen here: the address-and-strobe port.
`default_nettype none
// How it works
// - no operation unless enable bit set; that bit also starts the fast oscillator
// - three update enables allow config, loader or application area writes
// - go bit stalls the cpu while the sequencer drives pump and flash
// - go clears itself at completion and the cpu resumes
// - erase and program times come from internal counts, not supply
// - trigger register writes need the timed-access unlock first
// - out-of-range address sets the fault flag
// - unknown command code sets the fault flag
// - erase or program of a locked area sets the fault flag
// - erase or program under brown-out with inhibit active sets the fault flag
// - brown-out inhibit only matters while brown-out detection is on and brown-out reset is off
// - hardware only sets the fault flag; software clears it
// - command selects erase, program or read and the target area
// - program data comes before go; read result lands in the data register
module iaf_top
  import iaf_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter logic [15:0] APP_LAST_ADDR = 16'h3FFF,
  parameter logic [15:0] LDR_LAST_ADDR = 16'h0FFF,
  parameter logic [15:0] CFG_LAST_ADDR = 16'h0007
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic cpu_hold,
  output logic osc_en,
  output logic pump_en,
  output logic flash_erase,
  output logic flash_prog,
  output logic flash_read,
  output logic [1:0] flash_area,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  input wire logic brownout_detect_on,
  input wire logic brownout_reset_on,
  input wire logic supply_below_bod
);
  typedef struct packed {
    iaf_state_t state;
    iaf_op_t op;
    logic flash_op_enable;
    logic bank_sel;
    logic op_fault_flag;
    logic [2:0] area_update_enables;
    logic [7:0] target_addr_hi;
    logic [7:0] target_addr_lo;
    logic [7:0] flash_data_byte;
    logic [7:0] op_command_reg;
    logic [7:0] brownout_config_byte;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
  } iaf_regs_t;

  iaf_regs_t s;
  iaf_regs_t n;

  logic ta_open;
  logic prot_wr;
  logic lock_wr;
  logic tmr_start;
  logic tmr_abort;
  logic [TMR_W-1:0] tmr_load;
  logic tmr_done;
  logic go_req;
  logic [3:0] function_code;
  logic [1:0] block_select;
  logic cmd_ok;
  logic addr_ok;
  logic upd_ok;
  logic bo_block;
  logic start_fault;
  logic set_fault;
  logic set_done;
  iaf_op_t op_dec;
  logic [15:0] addr_full;
  logic [15:0] area_last;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  iaf_timed_access u_ta (
    .core_clk(core_clk),
    .nrst(nrst),
    .lock_wr(lock_wr),
    .lock_wdata(reg_wdata),
    .prot_wr(prot_wr),
    .open(ta_open)
  );

  iaf_op_timer u_tmr (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(tmr_start),
    .load(tmr_load),
    .abort(tmr_abort),
    .busy(),
    .done(tmr_done)
  );

  assign lock_wr = reg_wr && (reg_addr == ADR_TA_LOCK);
  assign prot_wr = reg_wr && (reg_addr == ADR_CHIP_CTRL || reg_addr == ADR_UPD_EN
                   || reg_addr == ADR_TRIGGER);

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign function_code = s.op_command_reg[CMD_FC_LSB +: 4];
  assign block_select = s.op_command_reg[CMD_BLK_LSB +: 2];
  assign addr_full = {s.target_addr_hi, s.target_addr_lo};

  always_comb
  begin
    op_dec = OP_READ;
    cmd_ok = 1'b0;
    if (!s.op_command_reg[CMD_FCEN_BIT])
    begin
      if (s.op_command_reg[CMD_FOEN_BIT] && function_code == FC_ERASE
          && block_select != 2'h3)
      begin
        op_dec = OP_ERASE;
        cmd_ok = 1'b1;
      end
      else if (s.op_command_reg[CMD_FOEN_BIT] && function_code == FC_PROG
               && block_select != 2'h3)
      begin
        op_dec = OP_PROG;
        cmd_ok = 1'b1;
      end
      else if (!s.op_command_reg[CMD_FOEN_BIT] && function_code == FC_READ
               && (block_select == BLK_APP || block_select == BLK_LDR))
      begin
        op_dec = OP_READ;
        cmd_ok = 1'b1;
      end
    end
  end

  always_comb
  begin
    area_last = APP_LAST_ADDR;
    upd_ok = s.area_update_enables[UPD_APP_BIT];
    if (block_select == BLK_LDR)
    begin
      area_last = LDR_LAST_ADDR;
      upd_ok = s.area_update_enables[UPD_LDR_BIT];
    end
    else if (block_select == BLK_CFG)
    begin
      area_last = CFG_LAST_ADDR;
      upd_ok = s.area_update_enables[UPD_CFG_BIT];
    end
  end

  assign addr_ok = (addr_full <= area_last);
  // inhibit only counts when detection is on and reset is off
  assign bo_block = s.brownout_config_byte[BO_INHIBIT_BIT] && brownout_detect_on
                    && !brownout_reset_on && supply_below_bod;
  assign start_fault = !cmd_ok
                       || !addr_ok
                       || (op_dec != OP_READ && !upd_ok)
                       || (op_dec != OP_READ && bo_block);

  always_comb
  begin
    tmr_load = TMR_W'(READ_CYC);
    unique case (op_dec)
      OP_ERASE: tmr_load = TMR_W'(ERASE_CYCLES);
      OP_PROG: tmr_load = TMR_W'(PROG_CYC);
      OP_READ: tmr_load = TMR_W'(READ_CYC);
      default: tmr_load = TMR_W'(READ_CYC);
    endcase
  end

  // ----------------------------------------
  // registers and sequencer
  // ----------------------------------------
  always_comb
  begin
    n = s;
    go_req = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    set_fault = 1'b0;
    set_done = 1'b0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADR_CHIP_CTRL:
        begin
          if (ta_open)
          begin
            n.flash_op_enable = reg_wdata[CHIP_EN_BIT];
            n.bank_sel = reg_wdata[CHIP_BS_BIT];
            n.op_fault_flag = reg_wdata[CHIP_FAULT_BIT];
          end
        end
        ADR_UPD_EN:
        begin
          if (ta_open)
          begin
            n.area_update_enables = reg_wdata[2:0];
          end
        end
        ADR_TRIGGER:
        begin
          // a go while disabled or locked is dropped silently
          go_req = ta_open && reg_wdata[TRIG_GO_BIT] && s.flash_op_enable
                   && s.state == ST_IDLE;
        end
        ADR_ADDR_LO: n.target_addr_lo = reg_wdata;
        ADR_ADDR_HI: n.target_addr_hi = reg_wdata;
        ADR_DATA: n.flash_data_byte = reg_wdata;
        ADR_CMD: n.op_command_reg = reg_wdata;
        ADR_BO_CFG: n.brownout_config_byte = reg_wdata;
        ADR_IRQ_STAT: n.irq_stat = s.irq_stat & ~reg_wdata[1:0];
        ADR_IRQ_MASK: n.irq_mask = reg_wdata[1:0];
        default: n.rdata = s.rdata;
      endcase
    end
    unique case (s.state)
      ST_IDLE:
      begin
        if (go_req)
        begin
          n.op = op_dec;
          if (start_fault)
          begin
            set_fault = 1'b1;
            n.state = ST_END;
          end
          else
          begin
            tmr_start = 1'b1;
            n.state = ST_RUN;
          end
        end
      end
      ST_RUN:
      begin
        if (s.op != OP_READ && bo_block)
        begin
          // supply sagged mid-operation: stop driving the array
          tmr_abort = 1'b1;
          set_fault = 1'b1;
          n.state = ST_END;
        end
        else if (tmr_done)
        begin
          if (s.op == OP_READ)
          begin
            n.flash_data_byte = flash_rdata;
          end
          n.state = ST_END;
        end
      end
      ST_END:
      begin
        set_done = 1'b1;
        n.state = ST_IDLE;
      end
      default: n.state = ST_IDLE;
    endcase
    // hardware sets win over a software clear in the same cycle
    if (set_fault)
    begin
      n.op_fault_flag = 1'b1;
      n.irq_stat[IRQ_FAULT_BIT] = 1'b1;
    end
    if (set_done)
    begin
      n.irq_stat[IRQ_DONE_BIT] = 1'b1;
    end
    n.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADR_CHIP_CTRL: n.rdata = {1'b0, s.op_fault_flag, 4'h0, s.bank_sel,
                                  s.flash_op_enable};
        ADR_UPD_EN: n.rdata = {5'h00, s.area_update_enables};
        ADR_TRIGGER: n.rdata = 8'h00;
        ADR_ADDR_LO: n.rdata = s.target_addr_lo;
        ADR_ADDR_HI: n.rdata = s.target_addr_hi;
        ADR_DATA: n.rdata = s.flash_data_byte;
        ADR_CMD: n.rdata = s.op_command_reg;
        ADR_BO_CFG: n.rdata = s.brownout_config_byte;
        ADR_IRQ_STAT: n.rdata = {6'h00, s.irq_stat};
        ADR_IRQ_MASK: n.rdata = {6'h00, s.irq_mask};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s.state <= ST_IDLE;
      s.op <= OP_READ;
      s.flash_op_enable <= RST_CHIP[CHIP_EN_BIT];
      s.bank_sel <= RST_CHIP[CHIP_BS_BIT];
      s.op_fault_flag <= RST_CHIP[CHIP_FAULT_BIT];
      s.area_update_enables <= RST_UPD;
      s.target_addr_hi <= RST_BYTE;
      s.target_addr_lo <= RST_BYTE;
      s.flash_data_byte <= RST_BYTE;
      s.op_command_reg <= RST_CMD;
      s.brownout_config_byte <= RST_BO_CFG;
      s.irq_stat <= RST_IRQ;
      s.irq_mask <= RST_IRQ;
      s.rdata <= RST_BYTE;
    end
    else
    begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = s.rdata;
  assign irq = |(s.irq_stat & s.irq_mask);
  assign cpu_hold = (s.state != ST_IDLE);
  // oscillator stays up until a running operation is over
  assign osc_en = s.flash_op_enable || (s.state != ST_IDLE);
  assign pump_en = (s.state == ST_RUN) && (s.op != OP_READ);
  assign flash_erase = (s.state == ST_RUN) && (s.op == OP_ERASE);
  assign flash_prog = (s.state == ST_RUN) && (s.op == OP_PROG);
  assign flash_read = (s.state == ST_RUN) && (s.op == OP_READ);
  assign flash_area = block_select;
  assign flash_addr = addr_full;
  assign flash_wdata = s.flash_data_byte;
endmodule
`default_nettype wire
